// ### hw/ncq_abort_device.sv
// device end: decodes queued non-data command and runs queue abort
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ncq_abort_device #(
	parameter int QDEPTH = 32
) (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	ncq_abort_if.device LINK,
	input wire logic NCQ_ENABLE_IN, // queuing enabled setting
	input wire logic [31:0] OUTSTANDING_IN, // queued commands in flight
	input wire logic [31:0] STREAMING_IN, // which of them are streaming
	input wire logic [31:0] FINISHED_IN, // commands finished meanwhile
	output logic [31:0] CANCEL_OUT, // one-cycle cancel strobe per tag
	output logic [7:0] STATUS_OUT, // last status flags
	output logic [7:0] ERROR_OUT // last error flags
);
	typedef enum logic [1:0] {IDLE, EXEC, REPLY} state_t;
	state_t state_q; // sequencer state
	logic [7:0] feat_q; // captured feature: type high, subcommand low
	logic [7:0] count_q; // captured count: own tag in the top five bits
	logic [7:0] number_q; // captured number: target tag in the top five bits
	logic [7:0] opc_q; // captured opcode
	logic [31:0] cancel_d; // tags to cancel for this command
	logic [31:0] done_mask_d; // completion bits to report on success
	logic fail_d; // command must be answered as aborted
	logic [4:0] tag; // tag of the abort command itself
	logic [4:0] ttag; // target tag, meaningful for selected abort only
	logic [3:0] atype; // requested abort type
	logic is_exec; // decision cycle, answer registered at its end

	////////////////////////////////////////////////////////////////
	// helper functions

	// five-bit tag from the top of a count or number byte
	function automatic logic [4:0] tag_field(input logic [7:0] field);
		return field[7:ncq_abort_pkg::TAG_LSB];
	endfunction

	// one bit per type code in the published list
	function automatic logic type_supported(input logic [3:0] t);
		return ncq_abort_pkg::TYPES_SUPPORTED[t];
	endfunction

	// ready always set, then either error or seek complete
	function automatic logic [7:0] status_word(input logic failed);
		logic [7:0] s;
		s = 8'h00;
		s[ncq_abort_pkg::ST_RDY] = 1'b1;
		if (failed) begin
			s[ncq_abort_pkg::ST_ERR] = 1'b1;
		end else begin
			s[ncq_abort_pkg::ST_DSC] = 1'b1;
		end
		// busy and device fault are never reported with an answer
		s[ncq_abort_pkg::ST_BSY] = 1'b0;
		s[ncq_abort_pkg::ST_DF] = 1'b0;
		return s;
	endfunction

	// only the abort bit is ever reported by this block
	function automatic logic [7:0] error_word(input logic failed);
		logic [7:0] e;
		e = 8'h00;
		e[ncq_abort_pkg::ER_ABT] = failed;
		return e;
	endfunction

	// queue subset named by a supported type other than selected
	function automatic logic [31:0] type_set(input logic [3:0] t, input logic [31:0] outst,
		input logic [31:0] strm);
		logic [31:0] m;
		m = 32'h00000000;
		case (t)
			ncq_abort_pkg::TYPE_ALL: m = outst;
			ncq_abort_pkg::TYPE_STREAM: m = outst & strm;
			ncq_abort_pkg::TYPE_NONSTREAM: m = outst & ~strm;
			default: m = 32'h00000000;
		endcase
		return m;
	endfunction

	////////////////////////////////////////////////////////////////
	// field extraction from the captured command
	assign tag = tag_field(count_q);
	assign ttag = tag_field(number_q);
	assign atype = feat_q[7:ncq_abort_pkg::TYPE_LSB];
	assign is_exec = (state_q == EXEC);
	// ready only while idle; a command offered in exec or reply is not taken
	assign LINK.cmd_ready = (state_q == IDLE);
	// the list is a constant, so the host may read it before any abort
	assign LINK.log_types = ncq_abort_pkg::TYPES_SUPPORTED;

	// validity and cancel set, from the captured fields and the live queue image
	always_comb begin
		fail_d = 1'b0;
		cancel_d = 32'h00000000;
		// checks run in a fixed order; the first one that trips decides
		if (opc_q != ncq_abort_pkg::CMD_NCQ_NON_DATA) begin
			fail_d = 1'b1; // foreign opcode is refused too
		end else if (feat_q[3:ncq_abort_pkg::SUB_LSB] != ncq_abort_pkg::SUB_ABORT) begin
			fail_d = 1'b1; // other subcommands belong elsewhere
		end else if (!NCQ_ENABLE_IN) begin
			fail_d = 1'b1;
		end else if (!type_supported(atype)) begin
			fail_d = 1'b1;
		end else if (atype == ncq_abort_pkg::TYPE_SELECTED) begin
			if (ttag == tag) begin
				fail_d = 1'b1;
			end else if (32'(ttag) >= 32'(QDEPTH)) begin
				fail_d = 1'b1;
			end else begin
				// a target that is not outstanding still completes, cancelling nothing
				cancel_d[ttag] = OUTSTANDING_IN[ttag];
			end
		end else begin
			// target tag ignored here, even when it equals the own tag
			cancel_d = type_set(atype, OUTSTANDING_IN, STREAMING_IN);
		end
		// finished commands ride along on the same completion bits
		done_mask_d = cancel_d | FINISHED_IN;
		done_mask_d[tag] = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// command capture and sequencing
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state_q <= IDLE;
			feat_q <= 8'h00;
			count_q <= 8'h00;
			number_q <= 8'h00;
			opc_q <= 8'h00;
		end else begin
			case (state_q)
				IDLE: begin
					if (LINK.cmd_valid) begin
						opc_q <= LINK.cmd_opcode;
						feat_q <= LINK.cmd_feature;
						count_q <= LINK.cmd_count;
						number_q <= LINK.cmd_number;
						state_q <= EXEC;
					end
				end
				EXEC: state_q <= REPLY;
				REPLY: state_q <= IDLE;
				default: state_q <= IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// answer path; every output below is a flop loaded at the end of exec

	// cancel strobe: one cycle, only on success, so a refused abort touches nothing
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			CANCEL_OUT <= 32'h00000000;
		end else if (is_exec && !fail_d) begin
			CANCEL_OUT <= cancel_d;
		end else begin
			CANCEL_OUT <= 32'h00000000;
		end
	end

	// completion pulse for every command, good or refused
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			LINK.done_valid <= 1'b0;
		end else begin
			LINK.done_valid <= is_exec;
		end
	end

	// status and error words travel with the pulse and hold until the next one
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			LINK.done_status <= 8'h00;
			LINK.done_error <= 8'h00;
		end else if (is_exec) begin
			LINK.done_status <= status_word(fail_d);
			LINK.done_error <= error_word(fail_d);
		end
	end

	// completion bits only on success; a refused command sends none
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			LINK.sdb_valid <= 1'b0;
		end else begin
			LINK.sdb_valid <= is_exec && !fail_d;
		end
	end

	// completion bit vector holds its last value between pulses
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			LINK.sdb_act <= 32'h00000000;
		end else if (is_exec && !fail_d) begin
			LINK.sdb_act <= done_mask_d;
		end
	end

	// local copy of the last result for the rest of the drive
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			STATUS_OUT <= 8'h00;
			ERROR_OUT <= 8'h00;
		end else if (is_exec) begin
			STATUS_OUT <= status_word(fail_d);
			ERROR_OUT <= error_word(fail_d);
		end
	end
endmodule
`default_nettype wire

// ### hw/ncq_abort_host.sv
// host end: apb-programmed issuer of queued non-data commands
`timescale 1ns/1ps
`default_nettype none
module ncq_abort_host (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	ncq_abort_if.host LINK,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic IRQ_OUT
);
	logic [31:0] cmd_q; // opcode, feature, count, number packed
	logic [15:0] result_q; // error, status
	logic [31:0] act_q;
	logic [1:0] irq_stat_q, irq_mask_q; // bit0 done, bit1 completion bits
	logic pend_q; // issue pending
	logic wr, rd, known;
	assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
	assign PREADY_OUT = 1'b1; // zero wait states
	assign known = (PADDR_IN <= ncq_abort_pkg::REG_LOG) && (PADDR_IN[1:0] == 2'b00);
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~known;
	assign IRQ_OUT = |(irq_stat_q & irq_mask_q);

	////////////////////////////////////////////////////////////////
	// command register and issue; opcode is sent as software wrote it
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			cmd_q <= 32'h00000000;
			pend_q <= 1'b0;
			irq_mask_q <= 2'h0;
		end else begin
			if (wr && PADDR_IN == ncq_abort_pkg::REG_CMD) cmd_q <= PWDATA_IN;
			if (wr && PADDR_IN == ncq_abort_pkg::REG_IRQ_MASK) irq_mask_q <= PWDATA_IN[1:0];
			if (wr && PADDR_IN == ncq_abort_pkg::REG_CTRL && PWDATA_IN[0]) begin
				pend_q <= 1'b1;
			end else if (pend_q && LINK.cmd_ready) begin
				pend_q <= 1'b0;
			end
		end
	end
	assign LINK.cmd_valid = pend_q & LINK.cmd_ready;
	assign LINK.cmd_opcode = cmd_q[31:24];
	assign LINK.cmd_feature = cmd_q[23:16];
	assign LINK.cmd_count = cmd_q[15:8]; // software keeps tag unique, in depth
	assign LINK.cmd_number = cmd_q[7:0];

	// results and sticky events, set wins over write-one clear
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			result_q <= 16'h0000;
			act_q <= 32'h00000000;
			irq_stat_q <= 2'h0;
		end else begin
			if (LINK.done_valid) result_q <= {LINK.done_error, LINK.done_status};
			if (LINK.sdb_valid) act_q <= LINK.sdb_act;
			irq_stat_q <= (irq_stat_q & ~((wr && PADDR_IN == ncq_abort_pkg::REG_IRQ_STAT)
				? PWDATA_IN[1:0] : 2'h0)) | {LINK.sdb_valid, LINK.done_valid};
		end
	end

	// read mux
	always_comb begin
		PRDATA_OUT = 32'h00000000;
		if (rd) begin
			case (PADDR_IN)
				ncq_abort_pkg::REG_CTRL: PRDATA_OUT = {31'h0, pend_q};
				ncq_abort_pkg::REG_CMD: PRDATA_OUT = cmd_q;
				ncq_abort_pkg::REG_RESULT: PRDATA_OUT = {16'h0, result_q};
				ncq_abort_pkg::REG_ACT: PRDATA_OUT = act_q;
				ncq_abort_pkg::REG_IRQ_STAT: PRDATA_OUT = {30'h0, irq_stat_q};
				ncq_abort_pkg::REG_IRQ_MASK: PRDATA_OUT = {30'h0, irq_mask_q};
				ncq_abort_pkg::REG_LOG: PRDATA_OUT = {16'h0, LINK.log_types};
				default: PRDATA_OUT = 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### hw/ncq_abort_if.sv
// link between host command issuer and device abort handler
`timescale 1ns/1ps
`default_nettype none
interface ncq_abort_if;
	logic cmd_valid; // one-cycle command pulse from host
	logic [7:0] cmd_opcode;
	logic [7:0] cmd_feature;
	logic [7:0] cmd_count;
	logic [7:0] cmd_number;
	logic cmd_ready; // device idle, command accepted
	logic done_valid; // one-cycle completion pulse
	logic [7:0] done_status;
	logic [7:0] done_error;
	logic sdb_valid; // one-cycle completion bits pulse
	logic [31:0] sdb_act;
	logic [15:0] log_types; // published abort types
	modport host (
		output cmd_valid, cmd_opcode, cmd_feature, cmd_count, cmd_number,
		input cmd_ready, done_valid, done_status, done_error, sdb_valid, sdb_act, log_types
	);
	modport device (
		input cmd_valid, cmd_opcode, cmd_feature, cmd_count, cmd_number,
		output cmd_ready, done_valid, done_status, done_error, sdb_valid, sdb_act, log_types
	);
endinterface
`default_nettype wire

// ### hw/ncq_abort_pkg.sv
// constants shared by the queued abort device end and its host end
// Behaviour
// - opcode 63h selects queued non-data family
// - feature bits 3-0 select subcommand, 0h abort
// - abort type taken from feature bits 7-4
// - host places unique tag in count 7-3
// - host tags stay within reported queue depth
// - target tag in number 7-3, within depth
// - target tag checked only for type 3h
// - type 0h cancels every outstanding command
// - 1h streaming only, 2h non-streaming only
// - type 3h cancels the one target tag
// - supported type completes successfully unless aborted below
// - completion bits set for abort and cancelled
// - completion may report other finished commands
// - queuing disabled gives command aborted
// - target equal to own tag is aborted
// - invalid target tag number is aborted
// - unsupported abort type is aborted
// - supported types published in log 12h
package ncq_abort_pkg;
	localparam logic [7:0] CMD_NCQ_NON_DATA = 8'h63;
	localparam logic [3:0] SUB_ABORT = 4'h0;
	localparam logic [3:0] TYPE_ALL = 4'h0;
	localparam logic [3:0] TYPE_STREAM = 4'h1;
	localparam logic [3:0] TYPE_NONSTREAM = 4'h2;
	localparam logic [3:0] TYPE_SELECTED = 4'h3;
	localparam logic [7:0] LOG_NCQ_NON_DATA = 8'h12;
	// supported abort types, one bit per type code
	localparam logic [15:0] TYPES_SUPPORTED = 16'h000F;
	localparam int SUB_LSB = 0;
	localparam int TYPE_LSB = 4;
	localparam int TAG_LSB = 3;
	// status and error bit positions
	localparam int ST_ERR = 0;
	localparam int ST_DSC = 4;
	localparam int ST_DF = 5;
	localparam int ST_RDY = 6;
	localparam int ST_BSY = 7;
	localparam int ER_ABT = 2;
	// host apb register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_RESULT = 8'h08;
	localparam logic [7:0] REG_ACT = 8'h0C;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	localparam logic [7:0] REG_LOG = 8'h18;
endpackage

// ### verification/ncq_abort_monitor.sv
// checker watching the link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module ncq_abort_monitor (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] cmd_feature,
	input wire logic [7:0] cmd_count,
	input wire logic [7:0] cmd_number,
	input wire logic cmd_ready,
	input wire logic done_valid,
	input wire logic [7:0] done_status,
	input wire logic [7:0] done_error,
	input wire logic sdb_valid,
	input wire logic [31:0] sdb_act,
	input wire logic [15:0] log_types
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// accepted command, accepted abort subcommand, aborted answer
	sequence s_take; cmd_valid && cmd_ready; endsequence
	sequence s_abt; s_take ##0 cmd_opcode == 8'h63 && cmd_feature[3:0] == 4'h0; endsequence
	sequence s_fail; done_valid && done_status == 8'h41 && done_error == 8'h04; endsequence
	////////////////////////////////////////////////////////////////
	done_lat_a: assert property (s_take |-> !done_valid ##1 !done_valid ##1 done_valid)
		else $error("completion not two cycles after command");
	busy_hold_a: assert property (s_take |=> !cmd_ready [*2] ##1 cmd_ready)
		else $error("ready not dropped for execution");
	ok_flags_a: assert property (sdb_valid |-> done_valid && done_status == 8'h50 && done_error == 8'h00)
		else $error("success flags wrong");
	sdb_on_ok_a: assert property (done_valid && !done_status[0] |-> sdb_valid)
		else $error("success without completion bits");
	fail_flags_a: assert property (done_valid && done_status[0] |-> s_fail ##0 !sdb_valid)
		else $error("aborted flags wrong");
	own_tag_a: assert property (s_abt ##0 cmd_feature[7:4] == 4'h3 && cmd_count[7:3] == cmd_number[7:3] |-> ##2 s_fail)
		else $error("own target tag not aborted");
	bad_type_a: assert property (s_abt ##0 cmd_feature[7:4] > 4'h3 |-> ##2 s_fail)
		else $error("unsupported type not aborted");
	bad_op_a: assert property (s_take ##0 cmd_opcode != 8'h63 |-> ##2 s_fail)
		else $error("foreign opcode not aborted");
	act_own_a: assert property (sdb_valid |-> sdb_act[$past(cmd_count[7:3], 2)])
		else $error("own tag missing from completion bits");
	log_list_a: assert property (log_types == 16'h000F)
		else $error("published type list wrong");
endmodule
`default_nettype wire

// ### verification/ncq_non_data_abort_handler_tb.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module ncq_non_data_abort_handler_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, ncq_en = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, cancel_seen = 32'h0, prdata, cancel;
	logic pready, pslverr, irq, err_seen;
	logic [7:0] st_out, er_out;
	// queue image: streaming subset of outstanding, one finished tag
	logic [31:0] outst = 32'h0000F0F0, strm = 32'h00003030, fin = 32'h00000100;
	int error_cnt = 0, samples_checked = 0;
	ncq_abort_if lnk();
	// depth cut to 16 so a five-bit target tag can be invalid
	ncq_abort_device #(.QDEPTH(16)) ncq_abort_device_i (.MCLK_IN(clk), .RSTN_IN(rstn),
		.LINK(lnk.device), .NCQ_ENABLE_IN(ncq_en), .OUTSTANDING_IN(outst), .STREAMING_IN(strm),
		.FINISHED_IN(fin), .CANCEL_OUT(cancel), .STATUS_OUT(st_out), .ERROR_OUT(er_out));
	ncq_abort_host ncq_abort_host_i (.MCLK_IN(clk), .RSTN_IN(rstn), .LINK(lnk.host),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq));
	ncq_abort_monitor mon (.MCLK_IN(clk), .RSTN_IN(rstn), .cmd_valid(lnk.cmd_valid),
		.cmd_opcode(lnk.cmd_opcode), .cmd_feature(lnk.cmd_feature), .cmd_count(lnk.cmd_count),
		.cmd_number(lnk.cmd_number), .cmd_ready(lnk.cmd_ready), .done_valid(lnk.done_valid),
		.done_status(lnk.done_status), .done_error(lnk.done_error), .sdb_valid(lnk.sdb_valid),
		.sdb_act(lnk.sdb_act), .log_types(lnk.log_types));
	always #25 clk = ~clk;
	// cancel strobe lasts one cycle, so latch it at completion
	always @(posedge clk) if (lnk.done_valid === 1'b1) cancel_seen <= cancel;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, s);
		samples_checked++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			error_cnt++;
		end
	endtask
	// one apb transfer: setup cycle, then access until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err_seen = pslverr;
		if (n >= 20) chk("pready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// issue a command, then judge result, cancels, completion bits and interrupt
	task automatic run(input logic [7:0] op, ft, input logic [4:0] tg, tt, input logic ok,
		input logic [31:0] cx);
		logic [31:0] r;
		int n;
		apb(1'b1, ncq_abort_pkg::REG_CMD, {op, ft, tg, 3'h0, tt, 3'h0}, r);
		apb(1'b1, ncq_abort_pkg::REG_CTRL, 32'h1, r);
		n = 0;
		r = 32'h0;
		while (r[0] !== 1'b1 && n < 30) begin
			apb(1'b0, ncq_abort_pkg::REG_IRQ_STAT, 32'h0, r);
			n++;
		end
		chk("irq stat", ok ? 32'h3 : 32'h1, r & 32'h3);
		apb(1'b0, ncq_abort_pkg::REG_RESULT, 32'h0, r);
		chk("result", ok ? 32'h50 : 32'h441, {16'h0, r[15:0]});
		chk("status out", ok ? 32'h50 : 32'h41, {24'h0, st_out});
		chk("error out", ok ? 32'h0 : 32'h4, {24'h0, er_out});
		chk("cancel", ok ? cx : 32'h0, cancel_seen);
		apb(1'b0, ncq_abort_pkg::REG_ACT, 32'h0, r);
		if (ok) chk("act", cx | fin | (32'h1 << tg), r);
		apb(1'b1, ncq_abort_pkg::REG_IRQ_MASK, 32'h0, r);
		@(negedge clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, ncq_abort_pkg::REG_IRQ_MASK, 32'h3, r);
		@(negedge clk);
		chk("irq mask", 32'h1, {31'h0, irq});
		apb(1'b1, ncq_abort_pkg::REG_IRQ_STAT, 32'h3, r);
		apb(1'b0, ncq_abort_pkg::REG_IRQ_STAT, 32'h0, r);
		chk("irq clear", 32'h0, r & 32'h3);
		chk("irq line", 32'h0, {31'h0, irq});
	endtask
	// unmapped address and published type list
	task automatic t_bus();
		logic [31:0] r;
		apb(1'b0, 8'h40, 32'h0, r);
		chk("slverr", 32'h1, {31'h0, err_seen});
		apb(1'b0, ncq_abort_pkg::REG_LOG, 32'h0, r);
		chk("log", 32'h000F, {16'h0, r[15:0]});
		chk("slverr ok", 32'h0, {31'h0, err_seen});
		$display("bus test over");
	endtask
	// every type; target equal to own tag must be ignored below type 3
	task automatic t_types();
		logic [31:0] ex [4] = '{32'hF0F0, 32'h3030, 32'hC0C0, 32'h0020};
		for (int t = 0; t < 4; t++) begin
			run(8'h63, {t[3:0], 4'h0}, 5'd1, (t == 3) ? 5'd5 : 5'd1, 1'b1, ex[t]);
		end
		run(8'h63, 8'h30, 5'd1, 5'd2, 1'b1, 32'h0);
		$display("type test over");
	endtask
	task automatic t_errors();
		run(8'h63, 8'h30, 5'd4, 5'd4, 1'b0, 32'h0);
		run(8'h63, 8'h30, 5'd4, 5'd20, 1'b0, 32'h0);
		run(8'h63, 8'h40, 5'd4, 5'd5, 1'b0, 32'h0);
		run(8'h63, 8'hF0, 5'd4, 5'd5, 1'b0, 32'h0);
		run(8'h60, 8'h00, 5'd4, 5'd5, 1'b0, 32'h0);
		run(8'h63, 8'h01, 5'd4, 5'd5, 1'b0, 32'h0);
		ncq_en <= 1'b0;
		run(8'h63, 8'h00, 5'd4, 5'd5, 1'b0, 32'h0);
		ncq_en <= 1'b1;
		$display("error test over");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_bus();
		t_types();
		t_errors();
		report_and_stop();
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
